/* File: include/vfp_defs.svh */
// Register offsets, field positions, reset values and converter constants of the video input block.
`ifndef VFP_DEFS_SVH
`define VFP_DEFS_SVH
`define VFP_IDX_INPUT_CFG    8'h10
`define VFP_IDX_STATUS       8'h0b
`define VFP_IDX_CLAMP_HI     8'h24
`define VFP_IDX_CLAMP_LO     8'h25
`define VFP_IDX_CLAMP_WIDTH  8'h26
`define VFP_IDX_OUT_CFG      8'h28
`define VFP_IDX_SOG_CFG_A    8'h30
`define VFP_IDX_SOG_CFG_B    8'h31
`define VFP_IDX_CLAMP_CFG    8'h60
`define VFP_IDX_PHASE_GAIN   8'h74
`define VFP_IDX_SYNC_OUT_CFG 8'h7a
`define VFP_BIT_COMPONENT    4
`define VFP_BIT_DC_COUPLE    3
`define VFP_BIT_OUT_422      0
`define VFP_BIT_CSC_EN       6
`define VFP_BIT_COAST_CLAMP  2
`define VFP_BIT_MASK_DIS     4
`define VFP_BIT_SOG_LPF      4
`define VFP_RST_INPUT_CFG    8'h00
`define VFP_RST_CLAMP_HI     8'h00
`define VFP_RST_CLAMP_LO     8'h08
`define VFP_RST_CLAMP_WIDTH  8'h10
`define VFP_RST_SOG_CFG_A    8'h04
`define VFP_RST_SOG_CFG_B    8'h01
`define VFP_RST_PHASE_GAIN   8'h49
`define VFP_PHASE_GAIN_FULL  8'h4c
`define VFP_CHROMA_MID       10'h200
`define VFP_CHROMA_OFS       22'sd524288
`define VFP_ROUND            22'sd512
`define VFP_CY_R             22'sd306
`define VFP_CY_G             22'sd601
`define VFP_CY_B             22'sd117
`define VFP_CU_R             -22'sd176
`define VFP_CU_G             -22'sd347
`define VFP_CU_B             22'sd523
`define VFP_CV_R             22'sd523
`define VFP_CV_G             -22'sd438
`define VFP_CV_B             -22'sd85
`define VFP_ACT_TIMEOUT      20000
`endif

/* File: include/vfp_pkg.sv */
// Types shared by the video input block.
package vfp_pkg;
   typedef logic [9:0] vfp_pix_t;
   typedef enum logic [1:0] {
      VFP_SRC_SEPARATE  = 2'b00,
      VFP_SRC_COMPOSITE = 2'b01,
      VFP_SRC_SOG       = 2'b10
   } vfp_src_e;
endpackage

/* File: hdl/vfp_video_input.sv */
// Video input format, clamp timing and sync processing with an Avalon-MM register slave.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "vfp_defs.svh"

module vfp_activity #(
   parameter int TIMEOUT = `VFP_ACT_TIMEOUT
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic level,
   output logic      active
);
   logic        prev_q;
   logic [31:0] idle_q;
   // An edge marks the source active; a long quiet spell marks it idle.
   always_ff @(posedge mclk) begin
      if (rst) begin
         prev_q <= 1'b0;
         idle_q <= 32'h0;
         active <= 1'b0;
      end else begin
         prev_q <= level;
         if (level != prev_q) begin
            idle_q <= 32'h0;
            active <= 1'b1;
         end else if (idle_q >= 32'(TIMEOUT - 1)) begin
            active <= 1'b0;
         end else begin
            idle_q <= idle_q + 32'h1;
         end
      end
   end
endmodule

module vfp_video_input #(
   parameter int ACT_TIMEOUT = `VFP_ACT_TIMEOUT
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic [9:0]        avsAddress,
   input  wire logic              avsRead,
   input  wire logic              avsWrite,
   input  wire logic [31:0]       avsWriteData,
   input  wire logic [3:0]        avsByteEnable,
   output logic [31:0]            avsReadData,
   output logic                   avsWaitRequest,
   input  wire vfp_pkg::vfp_pix_t redIn,
   input  wire vfp_pkg::vfp_pix_t greenIn,
   input  wire vfp_pkg::vfp_pix_t blueIn,
   input  wire logic [7:0]        sogLevelIn,
   input  wire logic              hsyncIn,
   input  wire logic              vsyncIn,
   input  wire logic              coastIn,
   output vfp_pkg::vfp_pix_t      redOut,
   output vfp_pkg::vfp_pix_t      greenOut,
   output vfp_pkg::vfp_pix_t      blueOut,
   output logic                   horizontal_sync_output,
   output logic                   pllSyncOut,
   output logic                   clampOut,
   output logic                   dcCoupleOut,
   output logic [7:0]             phaseGainOut,
   output logic                   phaseFullOut
);
   logic [7:0]        inputCfg_q, clampHi_q, clampLo_q, clampWidth_q, outCfg_q;
   logic [7:0]        sogCfgA_q, sogCfgB_q, clampCfg_q, phaseGain_q, syncOutCfg_q;
   logic [7:0]        regIdx, statusVal;
   logic              hMeta_q, hSync_q, vMeta_q, vSync_q;
   logic              hAct, vAct, sogAct;
   logic [8:0]        sogSum;
   logic [7:0]        sogPrev_q, sogVal, sogRise, sogFall;
   logic              sogSliced_q;
   logic              rawSync, syncPass_q, maskOpen, protSeen_q, protDetect_q;
   logic [15:0]       lineCnt_q, period_q, pixCnt_q, clampStart;
   logic              syncD_q, trailEdge, coastLine_q, clampSuppress;
   logic [7:0]        clampLeft_q;
   logic              yuvMode, compMode, cscOn, pairPhase_q;
   logic signed [21:0] yAcc, uAcc, vAcc;
   vfp_pkg::vfp_pix_t chY_q, chU_q, chV_q, heldV_q;
   logic              yuv_q;
   vfp_pkg::vfp_src_e srcSel;

   function automatic vfp_pkg::vfp_pix_t sat10(input logic signed [21:0] acc);
      logic signed [21:0] t;
      t = acc >>> 10;
      if (t < 0) begin
         sat10 = 10'h000;
      end else if (t > 22'sd1023) begin
         sat10 = 10'h3ff;
      end else begin
         sat10 = t[9:0];
      end
   endfunction

   assign regIdx  = avsAddress[9:2];
   assign srcSel  = vfp_pkg::vfp_src_e'(inputCfg_q[1:0]);
   assign compMode = inputCfg_q[`VFP_BIT_COMPONENT];
   assign cscOn   = !compMode && outCfg_q[`VFP_BIT_CSC_EN];
   assign yuvMode = compMode || cscOn;
   assign statusVal = {3'h0, coastIn, protDetect_q, sogAct, vAct, hAct};
   // Bus slave: one wait cycle, then answer at the edge where waitrequest is low.
   always_ff @(posedge mclk) begin
      if (rst) begin
         avsWaitRequest <= 1'b1;
      end else if ((avsRead || avsWrite) && avsWaitRequest) begin
         avsWaitRequest <= 1'b0;
      end else begin
         avsWaitRequest <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         avsReadData <= 32'h0;
      end else if (avsRead && avsWaitRequest) begin
         case (regIdx)
            `VFP_IDX_INPUT_CFG:    avsReadData <= {24'h0, inputCfg_q};
            `VFP_IDX_STATUS:       avsReadData <= {24'h0, statusVal};
            `VFP_IDX_CLAMP_HI:     avsReadData <= {24'h0, clampHi_q};
            `VFP_IDX_CLAMP_LO:     avsReadData <= {24'h0, clampLo_q};
            `VFP_IDX_CLAMP_WIDTH:  avsReadData <= {24'h0, clampWidth_q};
            `VFP_IDX_OUT_CFG:      avsReadData <= {24'h0, outCfg_q};
            `VFP_IDX_SOG_CFG_A:    avsReadData <= {24'h0, sogCfgA_q};
            `VFP_IDX_SOG_CFG_B:    avsReadData <= {24'h0, sogCfgB_q};
            `VFP_IDX_CLAMP_CFG:    avsReadData <= {24'h0, clampCfg_q};
            `VFP_IDX_PHASE_GAIN:   avsReadData <= {24'h0, phaseGain_q};
            `VFP_IDX_SYNC_OUT_CFG: avsReadData <= {24'h0, syncOutCfg_q};
            default:               avsReadData <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         inputCfg_q   <= `VFP_RST_INPUT_CFG;
         clampHi_q    <= `VFP_RST_CLAMP_HI;
         clampLo_q    <= `VFP_RST_CLAMP_LO;
         clampWidth_q <= `VFP_RST_CLAMP_WIDTH;
         outCfg_q     <= 8'h00;
         sogCfgA_q    <= `VFP_RST_SOG_CFG_A;
         sogCfgB_q    <= `VFP_RST_SOG_CFG_B;
         clampCfg_q   <= 8'h00;
         phaseGain_q  <= `VFP_RST_PHASE_GAIN;
         syncOutCfg_q <= 8'h00;
      end else if (avsWrite && !avsWaitRequest && avsByteEnable[0]) begin
         case (regIdx)
            `VFP_IDX_INPUT_CFG:    inputCfg_q   <= avsWriteData[7:0];
            `VFP_IDX_CLAMP_HI:     clampHi_q    <= avsWriteData[7:0];
            `VFP_IDX_CLAMP_LO:     clampLo_q    <= avsWriteData[7:0];
            `VFP_IDX_CLAMP_WIDTH:  clampWidth_q <= avsWriteData[7:0];
            `VFP_IDX_OUT_CFG:      outCfg_q     <= avsWriteData[7:0];
            `VFP_IDX_SOG_CFG_A:    sogCfgA_q    <= avsWriteData[7:0];
            `VFP_IDX_SOG_CFG_B:    sogCfgB_q    <= avsWriteData[7:0];
            `VFP_IDX_CLAMP_CFG:    clampCfg_q   <= avsWriteData[7:0];
            `VFP_IDX_PHASE_GAIN:   phaseGain_q  <= avsWriteData[7:0];
            `VFP_IDX_SYNC_OUT_CFG: syncOutCfg_q <= avsWriteData[7:0];
            default:               ;
         endcase
      end
   end
   // Phase loop gain and coupling select drive the analog side through one register stage.
   always_ff @(posedge mclk) begin
      if (rst) begin
         phaseGainOut <= `VFP_RST_PHASE_GAIN;
         phaseFullOut <= 1'b0;
         dcCoupleOut  <= 1'b0;
      end else begin
         phaseGainOut <= phaseGain_q;
         phaseFullOut <= (phaseGain_q == `VFP_PHASE_GAIN_FULL);
         dcCoupleOut  <= inputCfg_q[`VFP_BIT_DC_COUPLE];
      end
   end
   // Sync pins pass two flip-flops before use.
   always_ff @(posedge mclk) begin
      if (rst) begin
         hMeta_q <= 1'b0;
         hSync_q <= 1'b0;
         vMeta_q <= 1'b0;
         vSync_q <= 1'b0;
      end else begin
         hMeta_q <= hsyncIn;
         hSync_q <= hMeta_q;
         vMeta_q <= vsyncIn;
         vSync_q <= vMeta_q;
      end
   end
   // Green sync slicer: optional two-tap low-pass, threshold above sync tip with hysteresis.
   assign sogSum  = {1'b0, sogLevelIn} + {1'b0, sogPrev_q};
   assign sogVal  = sogCfgB_q[`VFP_BIT_SOG_LPF] ? sogSum[8:1] : sogLevelIn;
   assign sogFall = {sogCfgA_q[3:0], 4'h0};
   assign sogRise = 8'(sogFall + {4'h0, sogCfgB_q[3:0]});
   always_ff @(posedge mclk) begin
      if (rst) begin
         sogPrev_q   <= 8'h00;
         sogSliced_q <= 1'b0;
      end else begin
         sogPrev_q <= sogLevelIn;
         if (sogVal < sogFall) begin
            sogSliced_q <= 1'b1;
         end else if (sogVal > sogRise) begin
            sogSliced_q <= 1'b0;
         end
      end
   end
   // One activity detector for each sync source.
   vfp_activity #(.TIMEOUT(ACT_TIMEOUT)) uActH (.mclk(mclk), .rst(rst), .level(hSync_q), .active(hAct));
   vfp_activity #(.TIMEOUT(ACT_TIMEOUT)) uActV (.mclk(mclk), .rst(rst), .level(vSync_q), .active(vAct));
   vfp_activity #(.TIMEOUT(ACT_TIMEOUT)) uActS (.mclk(mclk), .rst(rst), .level(sogSliced_q), .active(sogAct));
   // Copy-protection mask: pulses starting before half the measured line are removed.
   assign rawSync  = (srcSel == vfp_pkg::VFP_SRC_SOG) ? sogSliced_q : hSync_q;
   assign maskOpen = (lineCnt_q >= {1'b0, period_q[15:1]});
   always_ff @(posedge mclk) begin
      if (rst) begin
         syncPass_q   <= 1'b0;
         lineCnt_q    <= 16'h0;
         period_q     <= 16'h0;
         protSeen_q   <= 1'b0;
         protDetect_q <= 1'b0;
      end else begin
         if (rawSync && !syncPass_q && maskOpen) begin
            syncPass_q   <= 1'b1;
            period_q     <= lineCnt_q;
            lineCnt_q    <= 16'h0;
            protDetect_q <= protSeen_q;
            protSeen_q   <= 1'b0;
         end else begin
            if (!rawSync) begin
               syncPass_q <= 1'b0;
            end
            if (lineCnt_q != 16'hffff) begin
               lineCnt_q <= lineCnt_q + 16'h1;
            end
            if (rawSync && !syncPass_q) begin
               protSeen_q <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pllSyncOut <= 1'b0;
         horizontal_sync_output   <= 1'b0;
         syncD_q    <= 1'b0;
      end else begin
         pllSyncOut <= rawSync && (syncPass_q || maskOpen);
         horizontal_sync_output   <= syncOutCfg_q[`VFP_BIT_MASK_DIS] ? rawSync : (rawSync && (syncPass_q || maskOpen));
         syncD_q    <= pllSyncOut;
      end
   end
   // DC-restore clamp timed from the trailing edge of the cleaned sync.
   assign trailEdge     = syncD_q && !pllSyncOut;
   assign clampStart    = {clampHi_q, clampLo_q};
   assign clampSuppress = !clampCfg_q[`VFP_BIT_COAST_CLAMP] && (coastLine_q || coastIn);
   always_ff @(posedge mclk) begin
      if (rst) begin
         pixCnt_q    <= 16'h0;
         coastLine_q <= 1'b0;
      end else if (trailEdge) begin
         pixCnt_q    <= 16'h0;
         coastLine_q <= coastIn;
      end else begin
         if (pixCnt_q != 16'hffff) begin
            pixCnt_q <= pixCnt_q + 16'h1;
         end
         if (coastIn) begin
            coastLine_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         clampLeft_q <= 8'h00;
         clampOut    <= 1'b0;
      end else if (!trailEdge && pixCnt_q == clampStart && !inputCfg_q[`VFP_BIT_DC_COUPLE]
                   && !clampSuppress && clampWidth_q != 8'h00) begin
         clampLeft_q <= clampWidth_q;
         clampOut    <= 1'b1;
      end else if (clampLeft_q > 8'h01) begin
         clampLeft_q <= clampLeft_q - 8'h01;
      end else begin
         clampLeft_q <= 8'h00;
         clampOut    <= 1'b0;
      end
   end
   // Colour space converter with fixed coefficients scaled by 1024.
   always_comb begin
      yAcc = `VFP_CY_R * $signed({12'h000, redIn}) + `VFP_CY_G * $signed({12'h000, greenIn})
           + `VFP_CY_B * $signed({12'h000, blueIn}) + `VFP_ROUND;
      uAcc = `VFP_CU_R * $signed({12'h000, redIn}) + `VFP_CU_G * $signed({12'h000, greenIn})
           + `VFP_CU_B * $signed({12'h000, blueIn}) + `VFP_ROUND + `VFP_CHROMA_OFS;
      vAcc = `VFP_CV_R * $signed({12'h000, redIn}) + `VFP_CV_G * $signed({12'h000, greenIn})
           + `VFP_CV_B * $signed({12'h000, blueIn}) + `VFP_ROUND + `VFP_CHROMA_OFS;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         chY_q <= 10'h000;
         chU_q <= `VFP_CHROMA_MID;
         chV_q <= `VFP_CHROMA_MID;
         yuv_q <= 1'b0;
      end else begin
         yuv_q <= yuvMode;
         if (compMode) begin
            chY_q <= greenIn;
            chU_q <= blueIn ^ `VFP_CHROMA_MID;
            chV_q <= redIn ^ `VFP_CHROMA_MID;
         end else if (cscOn) begin
            chY_q <= sat10(yAcc);
            chU_q <= sat10(uAcc);
            chV_q <= sat10(vAcc);
         end else begin
            chY_q <= greenIn;
            chU_q <= blueIn;
            chV_q <= redIn;
         end
      end
   end
   // Output mapping; pixel pairs restart at each sync trailing edge.
   always_ff @(posedge mclk) begin
      if (rst) begin
         greenOut    <= 10'h000;
         blueOut     <= 10'h000;
         redOut      <= 10'h000;
         pairPhase_q <= 1'b0;
         heldV_q     <= `VFP_CHROMA_MID;
      end else begin
         greenOut    <= chY_q;
         pairPhase_q <= trailEdge ? 1'b0 : !pairPhase_q;
         if (yuv_q && outCfg_q[`VFP_BIT_OUT_422]) begin
            blueOut <= 10'h000;
            if (!pairPhase_q) begin
               redOut  <= chU_q;
               heldV_q <= chV_q;
            end else begin
               redOut  <= heldV_q;
            end
         end else begin
            blueOut <= chU_q;
            redOut  <= chV_q;
         end
      end
   end

   chk_bus_answer: assert property (@(posedge mclk) disable iff (rst)
      (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
      else $error("bus request not answered after one wait cycle");
   chk_clamp_width: assert property (@(posedge mclk) disable iff (rst)
      $rose(clampOut) && clampWidth_q == 8'h05 |-> clampOut [*5] ##1 !clampOut)
      else $error("clamp width differs from programmed count");
   chk_clamp_dc_off: assert property (@(posedge mclk) disable iff (rst)
      inputCfg_q[`VFP_BIT_DC_COUPLE] && $past(inputCfg_q[`VFP_BIT_DC_COUPLE]) |-> !$rose(clampOut))
      else $error("clamp started while dc coupled");
   chk_clamp_coast: assert property (@(posedge mclk) disable iff (rst)
      $rose(clampOut) |-> clampCfg_q[`VFP_BIT_COAST_CLAMP] || !$past(coastIn))
      else $error("clamp started on a coasting line");
   chk_clamp_start: assert property (@(posedge mclk) disable iff (rst)
      $rose(clampOut) |-> $past(pixCnt_q) == $past(clampStart))
      else $error("clamp started at wrong pixel");
   chk_blue_low: assert property (@(posedge mclk) disable iff (rst)
      $past(yuv_q) && $past(outCfg_q[`VFP_BIT_OUT_422]) |-> blueOut == 10'h000)
      else $error("blue output not low in 4:2:2");
   chk_comp_mid: assert property (@(posedge mclk) disable iff (rst)
      compMode && blueIn == 10'h000 |=> chU_q == `VFP_CHROMA_MID)
      else $error("component chroma black not at midscale");
   chk_phase_full: assert property (@(posedge mclk) disable iff (rst)
      phaseGain_q == `VFP_PHASE_GAIN_FULL |=> phaseFullOut && phaseGainOut == `VFP_PHASE_GAIN_FULL)
      else $error("full phase gain not signalled");
   chk_hsync_mask: assert property (@(posedge mclk) disable iff (rst)
      !syncOutCfg_q[`VFP_BIT_MASK_DIS] |=> horizontal_sync_output == pllSyncOut)
      else $error("masked sync differs from horizontal sync output");
   chk_csc_grey: assert property (@(posedge mclk) disable iff (rst)
      cscOn && redIn == greenIn && greenIn == blueIn |=> chU_q == `VFP_CHROMA_MID && chV_q == `VFP_CHROMA_MID)
      else $error("grey input gives chroma away from 512");
endmodule

/* File: verif/vfp_src_model.sv */
// Behavioural video source: line sync on the horizontal pin and on green, optional protection pulses.
`timescale 1ns/10ps
module vfp_src_model #(
   parameter int PERIOD = 200
) (
   input  wire logic  mclk,
   input  wire logic  rst,
   input  wire logic  protect,
   input  wire logic  coastReq,
   output logic       hsync = 1'b0,
   output logic [7:0] sogLevel = 8'hff,
   output logic       coast = 1'b0
);
   int  cnt = 0;
   wire pulse = (cnt < 10) || (protect && cnt >= 60 && cnt < 66);
   always @(posedge mclk) begin
      cnt <= (rst || cnt == PERIOD - 1) ? 0 : cnt + 1;
      hsync <= pulse;
      sogLevel <= pulse ? 8'h00 : 8'hff;
      coast <= coastReq;
   end
endmodule

/* File: verif/vfp_video_input_tb.sv */
// Self-checking testbench of the video input block.
`timescale 1ns/10ps
module vfp_video_input_tb;
   typedef struct packed {
      logic [7:0] c10, c28;
      logic [9:0] r, g, b, er, eg, eb;
   } vfp_row_s;
   logic              mclk = 0, rst = 1, avsRead = 0, avsWrite = 0, protect = 0, coastReq = 0;
   logic [9:0]        avsAddress = 0;
   logic [31:0]       avsWriteData = 0, q;
   logic [3:0]        avsByteEnable = 0;
   vfp_pkg::vfp_pix_t redIn = 0, greenIn = 0, blueIn = 0, redOut, greenOut, blueOut;
   wire  [31:0]       avsReadData;
   wire  [7:0]        sogLevelIn, phaseGainOut;
   wire               avsWaitRequest, hsyncIn, coastIn, horizontal_sync_output, pllSyncOut, clampOut, dcCoupleOut, phaseFullOut;
   int                bad_count = 0, checks_done = 0, d, w, p, h;
   logic [7:0]        ri [11] = '{8'h10, 8'h24, 8'h25, 8'h26, 8'h28, 8'h30, 8'h31, 8'h60, 8'h74, 8'h7a, 8'h05};
   logic [7:0]        rv [11] = '{8'h00, 8'h00, 8'h08, 8'h10, 8'h00, 8'h04, 8'h01, 8'h00, 8'h49, 8'h00, 8'h00};
   vfp_row_s          rows [10] = '{
      '{8'h00, 8'h00, 10'h123, 10'h045, 10'h3ff, 10'h123, 10'h045, 10'h3ff},
      '{8'h00, 8'h01, 10'h123, 10'h045, 10'h3ff, 10'h123, 10'h045, 10'h3ff},
      '{8'h00, 8'h40, 10'h3ff, 10'h3ff, 10'h3ff, 10'h200, 10'h3ff, 10'h200},
      '{8'h00, 8'h40, 10'h3ff, 10'h000, 10'h000, 10'h3ff, 10'h132, 10'h150},
      '{8'h00, 8'h40, 10'h000, 10'h000, 10'h3ff, 10'h1ab, 10'h075, 10'h3ff},
      '{8'h00, 8'h40, 10'h000, 10'h3ff, 10'h000, 10'h04a, 10'h258, 10'h0a5},
      '{8'h00, 8'h40, 10'h3ff, 10'h3ff, 10'h000, 10'h255, 10'h38a, 10'h000},
      '{8'h10, 8'h00, 10'h000, 10'h100, 10'h000, 10'h200, 10'h100, 10'h200},
      '{8'h10, 8'h00, 10'h3ff, 10'h040, 10'h001, 10'h1ff, 10'h040, 10'h201},
      '{8'h10, 8'h40, 10'h005, 10'h300, 10'h3fe, 10'h205, 10'h300, 10'h1fe}};

   vfp_video_input #(.ACT_TIMEOUT(256)) dut (.mclk(mclk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .redIn(redIn), .greenIn(greenIn), .blueIn(blueIn), .sogLevelIn(sogLevelIn),
      .hsyncIn(hsyncIn), .vsyncIn(hsyncIn), .coastIn(coastIn), .redOut(redOut), .greenOut(greenOut),
      .blueOut(blueOut), .horizontal_sync_output(horizontal_sync_output), .pllSyncOut(pllSyncOut), .clampOut(clampOut),
      .dcCoupleOut(dcCoupleOut), .phaseGainOut(phaseGainOut), .phaseFullOut(phaseFullOut));
   vfp_src_model src (.mclk(mclk), .rst(rst), .protect(protect), .coastReq(coastReq), .hsync(hsyncIn),
      .sogLevel(sogLevelIn), .coast(coastIn));

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task end_sim;
      $display("Checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task bus(input logic wr, input logic [7:0] idx, input logic [7:0] dat, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge mclk);
      avsAddress <= {idx, 2'b00};
      avsRead <= !wr;
      avsWrite <= wr;
      avsWriteData <= {24'h000000, dat};
      avsByteEnable <= be;
      do begin
         @(posedge mclk);
         n++;
      end while (avsWaitRequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         bad_count++;
      end
      q = avsReadData;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask

   task rises(input int n, output int pc, output int hc);
      logic pp, hp;
      pc = 0;
      hc = 0;
      pp = pllSyncOut;
      hp = horizontal_sync_output;
      repeat (n) begin
         @(posedge mclk);
         pc += (pllSyncOut === 1'b1 && pp !== 1'b1);
         hc += (horizontal_sync_output === 1'b1 && hp !== 1'b1);
         pp = pllSyncOut;
         hp = horizontal_sync_output;
      end
   endtask

   task clamp_line(output int dl, output int wd);
      int n;
      n = 0;
      dl = 0;
      wd = 0;
      while (pllSyncOut !== 1'b1 && n < 400) begin @(posedge mclk); n++; end
      while (pllSyncOut !== 1'b0 && n < 400) begin @(posedge mclk); n++; end
      while (clampOut !== 1'b1 && dl < 180) begin @(posedge mclk); dl++; end
      while (clampOut === 1'b1 && wd < 300) begin @(posedge mclk); wd++; end
      if (n >= 400) begin
         bad_count++;
      end
   endtask

   initial begin
      #400000;
      bad_count++;
      end_sim;
   end

   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      check("gain", phaseGainOut, 8'h49);
      check("full", phaseFullOut, 1'b0);
      check("dc", dcCoupleOut, 1'b0);
      for (int i = 0; i < 11; i++) begin
         bus(1'b0, ri[i], 8'h00, 4'hf);
         check("reg", q, {24'h000000, rv[i]});
      end
      bus(1'b1, 8'h26, 8'h33, 4'he);
      bus(1'b0, 8'h26, 8'h00, 4'hf);
      check("be", q, 32'h10);
      $display("Finished registers");
      foreach (rows[i]) begin
         bus(1'b1, 8'h10, rows[i].c10, 4'hf);
         bus(1'b1, 8'h28, rows[i].c28, 4'hf);
         redIn <= rows[i].r;
         greenIn <= rows[i].g;
         blueIn <= rows[i].b;
         repeat (3) @(posedge mclk);
         #1;
         check("red", redOut, rows[i].er);
         check("green", greenOut, rows[i].eg);
         check("blue", blueOut, rows[i].eb);
      end
      $display("Finished pixel rows");
      bus(1'b1, 8'h10, 8'h10, 4'hf);
      bus(1'b1, 8'h28, 8'h01, 4'hf);
      redIn <= 10'h010;
      greenIn <= 10'h155;
      blueIn <= 10'h020;
      repeat (3) @(posedge mclk);
      #1;
      p = redOut;
      check("blue422", blueOut, 10'h000);
      check("green422", greenOut, 10'h155);
      @(posedge mclk);
      #1;
      check("alt", ({p[9:0], redOut} === 20'h88210) || ({p[9:0], redOut} === 20'h84220), 1'b1);
      $display("Finished decimation");
      protect <= 1'b1;
      bus(1'b1, 8'h10, 8'h00, 4'hf);
      rises(800, p, h);
      rises(800, p, h);
      check("pll", p, 4);
      check("hout", h, 4);
      bus(1'b0, 8'h0b, 8'h00, 4'hf);
      check("status", q[4:0], 5'h0f);
      bus(1'b1, 8'h7a, 8'h10, 4'hf);
      rises(800, p, h);
      check("pllu", p, 4);
      check("houtu", h, 8);
      bus(1'b1, 8'h7a, 8'h00, 4'hf);
      bus(1'b1, 8'h31, 8'h11, 4'hf);
      bus(1'b1, 8'h10, 8'h02, 4'hf);
      rises(800, p, h);
      rises(800, p, h);
      check("sog", p, 4);
      protect <= 1'b0;
      $display("Finished sync");
      bus(1'b1, 8'h10, 8'h00, 4'hf);
      clamp_line(d, w);
      check("cwid", w, 16);
      check("cdly", d >= 9 && d <= 11, 1'b1);
      bus(1'b1, 8'h25, 8'h40, 4'hf);
      bus(1'b1, 8'h26, 8'h05, 4'hf);
      clamp_line(d, w);
      check("cwid5", w, 5);
      check("cdly40", d >= 65 && d <= 67, 1'b1);
      coastReq <= 1'b1;
      clamp_line(d, w);
      check("coast", w, 0);
      bus(1'b1, 8'h60, 8'h04, 4'hf);
      clamp_line(d, w);
      check("coastok", w, 5);
      coastReq <= 1'b0;
      bus(1'b1, 8'h10, 8'h08, 4'hf);
      clamp_line(d, w);
      check("dcon", dcCoupleOut, 1'b1);
      check("dcclamp", w, 0);
      $display("Finished clamp");
      bus(1'b1, 8'h74, 8'h4c, 4'hf);
      repeat (2) @(posedge mclk);
      #1;
      check("gfull", phaseFullOut, 1'b1);
      check("gval", phaseGainOut, 8'h4c);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      check("grst", phaseGainOut, 8'h49);
      check("frst", phaseFullOut, 1'b0);
      $display("Finished gain");
      end_sim;
   end
endmodule
